// ==== twrc_core.sv ====
/*
 * heartbeat watchdog driving two relays from a cyclic process image.
 * assumes one clock, inputs synchronous to it, and a one-cycle
 * image_valid_i strobe for each process image cycle.
 */
// What this block does
// - watchdog period held in a register, default 4 ms
// - no heartbeat bit change within the period drops both relays
// - after a trip relays stay off at least minimum off time, default 50 ms
// - image carries status byte plus input word, control byte plus output word
// - control and status at byte 0, word at byte 1 or 2 when aligned
// - full image always presented, compact requests ignored
// - control bit 7 low selects heartbeat mode, bits 6 to 2 zero; block checks only bit 7 and ignores bits 6 to 1
// - status: ack bit 7, input 2 bit 3, input 1 bit 2, armed, echo
// - armed flag high only while monitoring runs and relays on
// - echo bit mirrors last received heartbeat bit
// - falling edge of input 1 arms monitoring and energises relays
// - after a trip only the enable input re-arms, not the heartbeat
`timescale 1ns/100ps
`include "twrc_defines.svh"

module twrc_core #(
    parameter logic [15:0] MS_CYCLES = 16'(`TWRC_MS_NS / `TWRC_CLK_NS)
) (
    // clock, reset, enable
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // process image
    input wire logic image_valid_i,
    input wire logic word_align_i,
    input wire logic compact_req_i,
    input wire logic [31:0] out_image_i,
    output logic [31:0] in_image_o,
    output logic [2:0] in_len_o,
    // field side
    input wire logic din1_i,
    input wire logic din2_i,
    output logic relay1_o,
    output logic relay2_o
);

    twrc_pkg::twrc_state_type state_r, state_nxt;
    twrc_pkg::twrc_ctrl_type ctrl_r;
    logic hb_r;
    logic din1_prev_r;
    logic pend_r;
    logic relay_r;
    logic [15:0] pre_r;
    logic [15:0] ms_cnt_r;
    logic [15:0] wd_period_r;
    logic [15:0] min_off_r;
    logic [31:0] in_image_r;
    logic [2:0] in_len_r;

    // image decode
    twrc_pkg::twrc_ctrl_type ctrl_w;
    logic [15:0] word_w;
    logic hb_mode_w;
    logic hb_edge_w;
    logic din1_fall_w;
    logic ms_tick_w;
    logic trip_w;
    logic off_done_w;
    logic restart_w;
    logic reg_wr_w;
    logic [5:0] reg_no_w;
    logic [15:0] rd_data_w;
    logic [7:0] stat_w;
    logic [15:0] in_word_w;
    logic [31:0] img_w;
    logic [2:0] len_w;
    twrc_pkg::twrc_stat_type hb_stat_w;

    assign ctrl_w = twrc_pkg::twrc_ctrl_type'(out_image_i[`TWRC_OFS_CTRL*8 +: 8]);
    assign word_w = word_align_i ? out_image_i[`TWRC_OFS_WORD_ALIGNED*8 +: 16]
                                 : out_image_i[`TWRC_OFS_WORD_PACKED*8 +: 16];
    assign hb_mode_w = image_valid_i && !ctrl_w.reg_sel;
    assign hb_edge_w = hb_mode_w && (ctrl_w.heartbeat != hb_r);
    assign din1_fall_w = din1_prev_r && !din1_i;
    assign ms_tick_w = (pre_r == MS_CYCLES - 16'h0001);
    assign trip_w = (state_r == twrc_pkg::TWRC_ARMED) && (ms_cnt_r >= wd_period_r);
    assign off_done_w = (ms_cnt_r >= min_off_r);
    assign restart_w = (state_nxt != state_r) ||
                       ((state_r == twrc_pkg::TWRC_ARMED) && hb_edge_w);

    // register exchange
    assign reg_no_w = {ctrl_w.mid, ctrl_w.heartbeat};
    assign reg_wr_w = image_valid_i && ctrl_w.reg_sel && ctrl_w.rw;
    assign rd_data_w = (ctrl_r.reg_sel && {ctrl_r.mid, ctrl_r.heartbeat} == `TWRC_REG_PERIOD)
                       ? wd_period_r
                       : (ctrl_r.reg_sel && {ctrl_r.mid, ctrl_r.heartbeat} == `TWRC_REG_MIN_OFF)
                       ? min_off_r : 16'h0000;

    assign hb_stat_w.reg_ack = 1'b0;
    assign hb_stat_w.rsv = 3'h0;
    assign hb_stat_w.din2 = din2_i;
    assign hb_stat_w.din1 = din1_i;
    assign hb_stat_w.armed = (state_r == twrc_pkg::TWRC_ARMED) && relay_r;
    assign hb_stat_w.echo = hb_r;
    assign stat_w = ctrl_r.reg_sel ? {1'b1, ctrl_r.rw, ctrl_r.mid, ctrl_r.heartbeat}
                                   : 8'(hb_stat_w);
    assign in_word_w = ctrl_r.reg_sel ? rd_data_w : 16'h0000;
    // full image regardless of compact request
    assign img_w = word_align_i ? {in_word_w, 8'h00, stat_w} : {8'h00, in_word_w, stat_w};
    assign len_w = word_align_i ? `TWRC_LEN_ALIGNED : `TWRC_LEN_PACKED;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            twrc_pkg::TWRC_IDLE: begin
                if (din1_fall_w) begin
                    state_nxt = twrc_pkg::TWRC_ARMED;
                end
            end
            twrc_pkg::TWRC_ARMED: begin
                if (trip_w) begin
                    state_nxt = twrc_pkg::TWRC_TRIPPED;
                end
            end
            twrc_pkg::TWRC_TRIPPED: begin
                if ((din1_fall_w || pend_r) && off_done_w) begin
                    state_nxt = twrc_pkg::TWRC_ARMED;
                end
            end
            default: begin
                state_nxt = twrc_pkg::TWRC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_r <= twrc_pkg::TWRC_IDLE;
            relay_r <= 1'b0;
            din1_prev_r <= 1'b0;
            pend_r <= 1'b0;
        end else if (ce_i) begin
            state_r <= state_nxt;
            relay_r <= (state_nxt == twrc_pkg::TWRC_ARMED);
            din1_prev_r <= din1_i;
            pend_r <= (state_r == twrc_pkg::TWRC_TRIPPED) && state_nxt != twrc_pkg::TWRC_ARMED
                      && (pend_r || din1_fall_w);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pre_r <= 16'h0000;
            ms_cnt_r <= 16'h0000;
        end else if (ce_i) begin
            pre_r <= (restart_w || ms_tick_w) ? 16'h0000 : pre_r + 16'h0001;
            if (restart_w) begin
                ms_cnt_r <= 16'h0000;
            end else if (ms_tick_w && ms_cnt_r != 16'hFFFF) begin
                ms_cnt_r <= ms_cnt_r + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            wd_period_r <= `TWRC_PERIOD_DEF;
            min_off_r <= `TWRC_MIN_OFF_DEF;
            ctrl_r <= '0;
            hb_r <= 1'b0;
        end else if (ce_i) begin
            if (reg_wr_w && reg_no_w == `TWRC_REG_PERIOD) begin
                wd_period_r <= word_w;
            end
            if (reg_wr_w && reg_no_w == `TWRC_REG_MIN_OFF) begin
                min_off_r <= word_w;
            end
            if (image_valid_i) begin
                ctrl_r <= ctrl_w;
            end
            if (hb_mode_w) begin
                hb_r <= ctrl_w.heartbeat;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            in_image_r <= 32'h0000_0000;
            in_len_r <= `TWRC_LEN_PACKED;
        end else if (ce_i) begin
            in_image_r <= img_w;
            in_len_r <= len_w;
        end
    end

    assign in_image_o = in_image_r;
    assign in_len_o = in_len_r;
    assign relay1_o = relay_r;
    assign relay2_o = relay_r;

    default clocking cb_main @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    AST_PERIOD_DEFAULT: assert property (
        $past(rst_i) |-> wd_period_r == `TWRC_PERIOD_DEF && min_off_r == `TWRC_MIN_OFF_DEF)
        else $error("timing registers not at default after reset");

    AST_TRIP_DROPS: assert property (
        (ce_i && state_r == twrc_pkg::TWRC_ARMED && ms_cnt_r >= wd_period_r) |=> !relay1_o)
        else $error("relays still on after period expiry");

    AST_MIN_OFF: assert property (
        (state_r == twrc_pkg::TWRC_TRIPPED && ms_cnt_r < min_off_r) |=> !relay1_o && !relay2_o)
        else $error("relays on before minimum off time");

    AST_FULL_IMAGE: assert property (
        compact_req_i |-> in_len_o >= `TWRC_LEN_PACKED)
        else $error("image shorter than full image");

    AST_ECHO: assert property (
        (ce_i && hb_mode_w) ##1 ce_i |=> in_image_o[0] == $past(out_image_i[0], 2))
        else $error("echo bit does not follow heartbeat");

    AST_ARMED_FLAG: assert property (
        (ce_i && !ctrl_r.reg_sel) |=> in_image_o[1] == $past(relay1_o))
        else $error("armed flag disagrees with relays");

    AST_DIN_STATUS: assert property (
        (ce_i && !ctrl_r.reg_sel) |=> in_image_o[3:2] == $past({din2_i, din1_i}))
        else $error("input status bits wrong");

    AST_REARM_CAUSE: assert property (
        $rose(relay1_o) |-> $past(din1_fall_w || pend_r))
        else $error("relays energised without enable edge");

    AST_EDGE_RESTART: assert property (
        (ce_i && state_r == twrc_pkg::TWRC_ARMED && hb_edge_w) |=> ms_cnt_r == 16'h0000)
        else $error("heartbeat edge did not restart count");

endmodule : twrc_core

// ==== twrc_defines.svh ====
/*
 * named constants of the toggle watchdog relay control block:
 * image layout, register numbers, reset values and timing.
 * assumes inclusion by bare name from the design files.
 */
`ifndef TWRC_DEFINES_SVH
`define TWRC_DEFINES_SVH

// timing
`define TWRC_CLK_NS 40
`define TWRC_MS_NS 1000000

// process image byte offsets and lengths
`define TWRC_OFS_CTRL 0
`define TWRC_OFS_WORD_PACKED 1
`define TWRC_OFS_WORD_ALIGNED 2
`define TWRC_LEN_PACKED 3'h3
`define TWRC_LEN_ALIGNED 3'h4

// register numbers
`define TWRC_REG_PERIOD 6'h23
`define TWRC_REG_MIN_OFF 6'h24

// reset values, in ms
`define TWRC_PERIOD_DEF 16'h0004
`define TWRC_MIN_OFF_DEF 16'h0032

`endif

// ==== twrc_pkg.sv ====
/*
 * types of the toggle watchdog relay control block.
 * assumes nothing of its surroundings.
 */
package twrc_pkg;

    typedef struct packed {
        logic reg_sel;
        logic rw;
        logic [4:0] mid;
        logic heartbeat;
    } twrc_ctrl_type;

    typedef struct packed {
        logic reg_ack;
        logic [2:0] rsv;
        logic din2;
        logic din1;
        logic armed;
        logic echo;
    } twrc_stat_type;

    typedef enum logic [1:0] {
        TWRC_IDLE,
        TWRC_ARMED,
        TWRC_TRIPPED
    } twrc_state_type;

endpackage : twrc_pkg

// ==== twrc_ctrl_model.sv ====
/*
 * controller model: sends one process image every 4 clock cycles.
 * assumes the bench clock; drives on the falling edge.
 */
`timescale 1ns/100ps

module twrc_ctrl_model (
    // clock
    input wire logic clk_sys_i,
    // commands from the bench
    input wire logic hb_en_i,
    input wire logic reg_go_i,
    input wire logic [7:0] reg_ctrl_i,
    input wire logic [15:0] reg_word_i,
    input wire logic word_align_i,
    // image to the block
    output logic image_valid_o,
    output logic [31:0] out_image_o
);
    logic [1:0] cnt_r = 2'h0;
    logic hb_r = 1'b0;
    logic [7:0] ctrl;
    // heartbeat mode, bits 6 to 2 zero
    assign ctrl = reg_go_i ? reg_ctrl_i : {7'h00, hb_r};
    always @(negedge clk_sys_i) begin
        cnt_r <= cnt_r + 2'h1;
        image_valid_o <= (cnt_r == 2'h0);
        if (cnt_r == 2'h2 && hb_en_i && !reg_go_i) begin
            hb_r <= ~hb_r;
        end
        // word at byte 1, or byte 2 when aligned
        if (cnt_r == 2'h0) begin
            out_image_o <= word_align_i ? {reg_word_i, 8'h00, ctrl} : {8'h00, reg_word_i, ctrl};
        end else begin
            out_image_o <= ~out_image_o;
        end
    end
endmodule : twrc_ctrl_model

// ==== tb_toggle_watchdog_relay_control.sv ====
/*
 * self-checking bench of the watchdog relay block with a controller model.
 * assumes MS_CYCLES of 4, so 1 ms is 4 clock cycles.
 */
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
    $display("Error %s expected %h seen %h", nm, exp, got); end end

module tb_toggle_watchdog_relay_control;
    logic clk_sys_i = 1'b0;
    logic rst_i, din1, din2, word_align, hb_en, reg_go, ce;
    logic [7:0] reg_ctrl;
    logic [15:0] reg_word;
    logic image_valid, relay1, relay2;
    logic [31:0] out_image, in_image;
    logic [2:0] in_len;
    int n_errors = 0;
    int checks_done = 0;

    always #20 clk_sys_i = ~clk_sys_i;

    twrc_ctrl_model u_ctl (.clk_sys_i(clk_sys_i), .hb_en_i(hb_en), .reg_go_i(reg_go),
        .reg_ctrl_i(reg_ctrl), .reg_word_i(reg_word), .word_align_i(word_align),
        .image_valid_o(image_valid), .out_image_o(out_image));

    twrc_core #(.MS_CYCLES(16'h0004)) u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .ce_i(ce), .image_valid_i(image_valid), .word_align_i(word_align),
        .compact_req_i(1'b1), .out_image_i(out_image), .in_image_o(in_image),
        .in_len_o(in_len), .din1_i(din1), .din2_i(din2), .relay1_o(relay1),
        .relay2_o(relay2));

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask : cyc

    task automatic wrap_up;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up

    task automatic reg_op(input logic [7:0] c, input logic [15:0] w);
        reg_ctrl = c;
        reg_word = w;
        reg_go = 1'b1;
        cyc(12);
    endtask : reg_op

    task automatic t_reset;
        `CHK("relay1", 1'b0, relay1)
        `CHK("in_len", 3'h3, in_len)
        `CHK("in_image", 32'h0000_0000, in_image)
    endtask : t_reset

    task automatic t_regs;
        reg_op(8'hA3, 16'h0000);
        `CHK("status rd", 8'hA3, in_image[7:0])
        `CHK("period def", 16'h0004, in_image[23:8])
        reg_op(8'hA4, 16'h0000);
        `CHK("min off def", 16'h0032, in_image[23:8])
        reg_op(8'hE4, 16'h0028);
        `CHK("min off wr", 16'h0028, in_image[23:8])
        reg_op(8'hE3, 16'h0008);
        `CHK("status wr", 8'hE3, in_image[7:0])
        word_align = 1'b1;
        reg_op(8'hA3, 16'h0000);
        `CHK("in_len al", 3'h4, in_len)
        `CHK("period al", 16'h0008, in_image[31:16])
        reg_op(8'hA5, 16'h0000);
        `CHK("unmapped", 16'h0000, in_image[31:16])
        word_align = 1'b0;
        reg_go = 1'b0;
        cyc(12);
        `CHK("in_len pk", 3'h3, in_len)
    endtask : t_regs

    task automatic t_arm_trip;
        hb_en = 1'b1;
        din2 = 1'b1;
        din1 = 1'b1;
        cyc(3);
        din1 = 1'b0;
        cyc(3);
        `CHK("relay1 arm", 1'b1, relay1)
        `CHK("relay2 arm", 1'b1, relay2)
        cyc(100);
        `CHK("relay1 hb", 1'b1, relay1)
        `CHK("status bits", 3'h5, in_image[3:1])
        `CHK("mode ack", 1'b0, in_image[7])
        hb_en = 1'b0;
        cyc(8);
        `CHK("echo", u_ctl.hb_r, in_image[0])
        cyc(16);
        `CHK("relay1 late", 1'b1, relay1)
        cyc(40);
        `CHK("relay1 trip", 1'b0, relay1)
        `CHK("relay2 trip", 1'b0, relay2)
        `CHK("armed trip", 1'b0, in_image[1])
    endtask : t_arm_trip

    task automatic t_rearm;
        hb_en = 1'b1;
        cyc(60);
        `CHK("relay1 hb only", 1'b0, relay1)
        din1 = 1'b1;
        cyc(3);
        din1 = 1'b0;
        cyc(20);
        `CHK("relay1 min off", 1'b0, relay1)
        cyc(60);
        `CHK("relay1 min off set", 1'b1, relay1)
        cyc(200);
        `CHK("relay1 rearm", 1'b1, relay1)
        `CHK("armed rearm", 1'b1, in_image[1])
    endtask : t_rearm

    task automatic t_freeze;
        ce = 1'b0;
        hb_en = 1'b0;
        din2 = 1'b0;
        cyc(60);
        `CHK("relay1 frozen", 1'b1, relay1)
        `CHK("din2 frozen", 1'b1, in_image[3])
        ce = 1'b1;
        hb_en = 1'b1;
        cyc(8);
        `CHK("relay1 resumed", 1'b1, relay1)
        `CHK("din2 resumed", 1'b0, in_image[3])
    endtask : t_freeze

    task automatic t_reset2;
        rst_i = 1'b1;
        cyc(2);
        rst_i = 1'b0;
        cyc(2);
        `CHK("relay1 rst2", 1'b0, relay1)
        `CHK("armed rst2", 1'b0, in_image[1])
        reg_op(8'hA3, 16'h0000);
        `CHK("period rst2", 16'h0004, in_image[23:8])
        reg_op(8'hA4, 16'h0000);
        `CHK("min off rst2", 16'h0032, in_image[23:8])
    endtask : t_reset2

    initial begin
        rst_i = 1'b1;
        din1 = 1'b0;
        din2 = 1'b0;
        word_align = 1'b0;
        hb_en = 1'b0;
        reg_go = 1'b0;
        ce = 1'b1;
        reg_ctrl = 8'h00;
        reg_word = 16'h0000;
        cyc(16);
        rst_i = 1'b0;
        cyc(2);
        t_reset();
        t_regs();
        t_arm_trip();
        t_rearm();
        t_freeze();
        t_reset2();
        wrap_up();
    end

    initial begin
        repeat (3000) @(posedge clk_sys_i);
        n_errors++;
        wrap_up();
    end
endmodule : tb_toggle_watchdog_relay_control
